// File: hdl/smcf_pkg.sv
// Shared constants, enumerations and carrier structs of the serial memory command front end
package smcf_pkg;

	// ============================================================
	// Opcodes, shifted in most significant bit first
	localparam logic [7:0] SMCF_OP_LATCH_SET = 8'h06; // latch_set_cmd
	localparam logic [7:0] SMCF_OP_LATCH_CLR = 8'h04; // latch_clear_cmd
	localparam logic [7:0] SMCF_OP_STAT_RD = 8'h05; // status_read_cmd
	localparam logic [7:0] SMCF_OP_STAT_WR = 8'h01; // status_write_cmd
	localparam logic [7:0] SMCF_OP_MEM_RD = 8'h03; // Memory read
	localparam logic [7:0] SMCF_OP_FAST_RD = 8'h0B; // fast_read_cmd
	localparam logic [7:0] SMCF_OP_MEM_WR = 8'h02; // Memory write
	localparam logic [7:0] SMCF_OP_SLEEP = 8'hB9; // Sleep entry
	localparam logic [7:0] SMCF_OP_IDENT = 8'h9F; // ident_read_cmd

	// ============================================================
	// Status register layout and reset values
	localparam int SMCF_SR_WEL_POS = 1; // write_enable_flag position
	localparam int SMCF_SR_BP0_POS = 2; // Block protect low bit
	localparam int SMCF_SR_BP1_POS = 3; // Block protect high bit
	localparam int SMCF_SR_WPEN_POS = 7; // Protect pin enable
	localparam logic [7:0] SMCF_SR_FIXED = 8'h40; // Bit 6 reads one, 5:4 and 0 read zero
	localparam logic [7:0] SMCF_SR_WR_MASK = 8'h8C; // Bits a status write may change
	localparam logic [7:0] SMCF_SR_RESET = 8'h00; // Writable bits after reset
	localparam logic SMCF_WEL_RESET = 1'b0; // Latch cleared after power-up

	// ============================================================
	// Framing counts
	localparam logic [2:0] SMCF_LAST_BIT = 3'h7; // Bit index that completes a byte
	localparam logic [15:0] SMCF_ADDR_RESET = 16'h0000; // Address after reset

	// Phase of a chip-select cycle
	typedef enum logic [2:0] {
		SMCF_IDLE,
		SMCF_OPCODE,
		SMCF_ADDR,
		SMCF_DUMMY,
		SMCF_DATA,
		SMCF_SKIP
	} smcf_phase_e;

	// Command taken in this chip-select cycle
	typedef enum logic [2:0] {
		SMCF_K_NONE,
		SMCF_K_CLR,
		SMCF_K_SRD,
		SMCF_K_SWR,
		SMCF_K_RD,
		SMCF_K_FRD,
		SMCF_K_WR,
		SMCF_K_ID
	} smcf_kind_e;

	// Request toward the memory array and identity source
	typedef struct packed {
		logic rd; // Fetch a byte at addr
		logic wr; // Store wdata at addr
		logic id; // Fetch the next identity byte
		logic [15:0] addr; // Byte address
		logic [7:0] wdata; // Byte to store
	} smcf_mem_req_s;

	// Whole state of the front end
	typedef struct packed {
		smcf_phase_e phase; // Sequence phase
		smcf_kind_e kind; // Decoded command
		logic mode3; // Clock idled high at selection
		logic armed; // Rising edges may sample
		logic [2:0] bitcnt; // Bit within byte
		logic [7:0] sh_in; // Input shifter
		logic addr_hi_done; // First address byte taken
		logic [15:0] addr; // Running address
		logic [7:0] sh_out; // Output shifter
		logic so_out; // Output bit
		logic so_oe; // Output driven
		logic write_enable_flag; // Write enable latch
		logic [7:0] sr; // Writable status bits
		logic sleep; // Sleep request pulse
		smcf_mem_req_s req; // Memory request
	} smcf_state_s;

endpackage

// File: hdl/smcf_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module smcf_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import smcf_pkg::*;

	logic [W-1:0] meta_reg; // First stage, read only by the second

	// ============================================================
	// Two flops in series
	// Both stages reset to the pins' idle levels, so no false edge follows reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// File: hdl/smcf_edge.sv
// Edge finder for synchronised levels
`timescale 1ns/100ps
module smcf_edge #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] lvl,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	import smcf_pkg::*;

	logic [W-1:0] prev_reg; // Level one cycle ago

	// ============================================================
	// Remember the previous level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_reg <= INIT;
		end else begin
			prev_reg <= lvl;
		end
	end

	// One-cycle pulses on each change
	assign rise = lvl & ~prev_reg;
	assign fall = ~lvl & prev_reg;
endmodule

// File: hdl/smcf_frontend.sv
// SPI slave command front end of a serial nonvolatile byte memory
`timescale 1ns/100ps
import smcf_pkg::*;

// Function
// - Sample on SCK rise, change output on fall
// - SCK level at select picks mode 0/3
// - Mode 3 samples after first clock toggle
// - First byte after select is opcode
// - One opcode per chip-select low period
// - Deselected: ignore input, output tristated
// - All bytes shift most significant first
// - Memory access takes sixteen-bit address
// - Invalid opcode: ignore rest, output tristated
// - Decode latch set and clear opcodes
// - Decode read, fast read, write opcodes
// - Decode status read and write opcodes
// - Decode sleep and identification opcodes
// - Latch cleared after reset, writes refused
// - Latch set command sets visible flag
// - Status write data never alters the flag
// - Chip-select rise clears latch after writes
// - Each write completes within its transfer
// - Holds an eight-bit status register
// - Flag appears at status bit one
module smcf_frontend (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so_out,
	output logic so_oe,
	output smcf_pkg::smcf_mem_req_s mem_req,
	input wire logic [7:0] rd_data,
	output logic sleep_req,
	output logic [7:0] status_byte
);
	import smcf_pkg::*;

	// ============================================================
	// Pin synchronisation and edge finding
	logic cs_n_s; // Synchronised chip select
	logic sck_s; // Synchronised serial clock
	logic si_s; // Synchronised serial input
	logic cs_rise; // Deselect pulse
	logic cs_fall; // Select pulse
	logic sck_rise; // Sampling edge pulse
	logic sck_fall; // Output edge pulse

	// Chip select idles high, so its stages reset high; clock and data reset low
	smcf_sync #(.W(3), .INIT(3'b100)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d({cs_n, sck, si}),
		.q({cs_n_s, sck_s, si_s})
	);

	smcf_edge #(.W(2), .INIT(2'b10)) u_edge (
		.clk(clk),
		.nrst(nrst),
		.lvl({cs_n_s, sck_s}),
		.rise({cs_rise, sck_rise}),
		.fall({cs_fall, sck_fall})
	);

	// ============================================================
	// State
	smcf_state_s st_reg; // Registered state
	smcf_state_s st_next; // Next state
	logic [7:0] sh_cat; // Input shifter with the new bit
	logic [7:0] out_src; // Byte to load into the output shifter
	logic is_read_kind; // Command drives the output

	// Visible status byte: fixed bits, writable bits and the latch
	always_comb begin
		status_byte = SMCF_SR_FIXED | (st_reg.sr & SMCF_SR_WR_MASK);
		status_byte[SMCF_SR_WEL_POS] = st_reg.write_enable_flag;
	end

	// Most significant bit arrives first, so shift toward the top
	assign sh_cat = {st_reg.sh_in[6:0], si_s};

	// Output source: status byte or fetched data
	assign out_src = (st_reg.kind == SMCF_K_SRD) ? status_byte : rd_data;

	// Commands that answer on the output
	assign is_read_kind = (st_reg.kind == SMCF_K_SRD) || (st_reg.kind == SMCF_K_RD) ||
		(st_reg.kind == SMCF_K_FRD) || (st_reg.kind == SMCF_K_ID);

	// ============================================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		// Request and sleep strobes last one cycle
		st_next.req.rd = 1'b0;
		st_next.req.wr = 1'b0;
		st_next.req.id = 1'b0;
		st_next.sleep = 1'b0;
		if (cs_fall) begin
			// New selection: opcode expected, mode from clock level
			st_next.phase = SMCF_OPCODE;
			st_next.kind = SMCF_K_NONE;
			st_next.mode3 = sck_s;
			st_next.armed = ~sck_s;
			st_next.bitcnt = 3'h0;
			st_next.addr_hi_done = 1'b0;
			st_next.so_oe = 1'b0;
		end else if (cs_rise || cs_n_s) begin
			// Deselected: drop the sequence and float the output
			st_next.phase = SMCF_IDLE;
			st_next.so_oe = 1'b0;
			if (cs_rise && ((st_reg.kind == SMCF_K_CLR) || (st_reg.kind == SMCF_K_SWR) ||
				(st_reg.kind == SMCF_K_WR))) begin
				st_next.write_enable_flag = 1'b0;
			end
			if (cs_rise) begin
				st_next.kind = SMCF_K_NONE;
			end
		end else if (sck_fall) begin
			// Output edge; in mode 3 the first fall arms sampling
			st_next.armed = 1'b1;
			if ((st_reg.phase == SMCF_DATA) && is_read_kind) begin
				if (st_reg.bitcnt == 3'h0) begin
					// Byte boundary: load a fresh byte
					st_next.so_out = out_src[7];
					st_next.sh_out = {out_src[6:0], 1'b0};
					st_next.so_oe = 1'b1;
				end else begin
					st_next.so_out = st_reg.sh_out[7];
					st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
				end
			end
		end else if (sck_rise && st_reg.armed) begin
			// Sampling edge
			st_next.sh_in = sh_cat;
			st_next.bitcnt = st_reg.bitcnt + 3'h1;
			case (st_reg.phase)
				SMCF_OPCODE: begin
					if (st_reg.bitcnt == SMCF_LAST_BIT) begin
						// Decode once; later bytes never reach here again
						st_next.phase = SMCF_SKIP;
						case (sh_cat)
							SMCF_OP_LATCH_SET: begin
								st_next.write_enable_flag = 1'b1;
							end
							SMCF_OP_LATCH_CLR: begin
								st_next.kind = SMCF_K_CLR;
							end
							SMCF_OP_STAT_RD: begin
								st_next.kind = SMCF_K_SRD;
								st_next.phase = SMCF_DATA;
							end
							SMCF_OP_STAT_WR: begin
								st_next.kind = SMCF_K_SWR;
								st_next.phase = SMCF_DATA;
							end
							SMCF_OP_MEM_RD: begin
								st_next.kind = SMCF_K_RD;
								st_next.phase = SMCF_ADDR;
							end
							SMCF_OP_FAST_RD: begin
								st_next.kind = SMCF_K_FRD;
								st_next.phase = SMCF_ADDR;
							end
							SMCF_OP_MEM_WR: begin
								st_next.kind = SMCF_K_WR;
								st_next.phase = SMCF_ADDR;
							end
							SMCF_OP_SLEEP: begin
								st_next.sleep = 1'b1;
							end
							SMCF_OP_IDENT: begin
								st_next.kind = SMCF_K_ID;
								st_next.phase = SMCF_DATA;
								st_next.req.id = 1'b1;
							end
							default: begin
								// Unknown opcode: nothing more this selection
								st_next.kind = SMCF_K_NONE;
							end
						endcase
					end
				end
				SMCF_ADDR: begin
					// Two address bytes, high first
					st_next.addr = {st_reg.addr[14:0], si_s};
					if (st_reg.bitcnt == SMCF_LAST_BIT) begin
						st_next.addr_hi_done = 1'b1;
						if (st_reg.addr_hi_done) begin
							if (st_reg.kind == SMCF_K_FRD) begin
								st_next.phase = SMCF_DUMMY;
							end else begin
								st_next.phase = SMCF_DATA;
								st_next.req.rd = (st_reg.kind == SMCF_K_RD);
								st_next.req.addr = {st_reg.addr[14:0], si_s};
							end
						end
					end
				end
				SMCF_DUMMY: begin
					// Fast read: one dummy byte before data
					if (st_reg.bitcnt == SMCF_LAST_BIT) begin
						st_next.phase = SMCF_DATA;
						st_next.req.rd = 1'b1;
						st_next.req.addr = st_reg.addr;
					end
				end
				SMCF_DATA: begin
					if (st_reg.bitcnt == SMCF_LAST_BIT) begin
						case (st_reg.kind)
							SMCF_K_SWR: begin
								// Only the writable bits; flag untouched
								if (st_reg.write_enable_flag) begin
									st_next.sr = sh_cat & SMCF_SR_WR_MASK;
								end
								st_next.phase = SMCF_SKIP;
							end
							SMCF_K_WR: begin
								// Store immediately, no busy time
								st_next.req.wr = st_reg.write_enable_flag;
								st_next.req.addr = st_reg.addr;
								st_next.req.wdata = sh_cat;
								st_next.addr = st_reg.addr + 16'h0001;
							end
							SMCF_K_RD, SMCF_K_FRD: begin
								// Prefetch the next sequential byte
								st_next.addr = st_reg.addr + 16'h0001;
								st_next.req.rd = 1'b1;
								st_next.req.addr = st_reg.addr + 16'h0001;
							end
							SMCF_K_ID: begin
								st_next.req.id = 1'b1;
							end
							default: begin
								st_next.phase = st_reg.phase;
							end
						endcase
					end
				end
				default: begin
					// Idle or skipping: input ignored
					st_next.phase = st_reg.phase;
				end
			endcase
		end
	end

	// ============================================================
	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '{
				phase: SMCF_IDLE,
				kind: SMCF_K_NONE,
				mode3: 1'b0,
				armed: 1'b0,
				bitcnt: 3'h0,
				sh_in: 8'h00,
				addr_hi_done: 1'b0,
				addr: SMCF_ADDR_RESET,
				sh_out: 8'h00,
				so_out: 1'b0,
				so_oe: 1'b0,
				write_enable_flag: SMCF_WEL_RESET,
				sr: SMCF_SR_RESET,
				sleep: 1'b0,
				req: '0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	assign so_out = st_reg.so_out;
	assign so_oe = st_reg.so_oe;
	assign mem_req = st_reg.req;
	assign sleep_req = st_reg.sleep;

	// ============================================================
	// Checks
	so_float_a: assert property (@(posedge clk) disable iff (!nrst)
		cs_n_s && !cs_fall |=> !so_oe)
		else $error("Output driven while deselected");

	skip_float_a: assert property (@(posedge clk) disable iff (!nrst)
		(st_reg.phase == SMCF_SKIP) && (st_reg.kind == SMCF_K_NONE) |-> !so_oe)
		else $error("Output driven after unusable opcode");

	mode_pick_a: assert property (@(posedge clk) disable iff (!nrst)
		cs_fall |=> (st_reg.mode3 == $past(sck_s)) && (st_reg.phase == SMCF_OPCODE))
		else $error("Mode not taken from clock level at select");

	out_edge_a: assert property (@(posedge clk) disable iff (!nrst)
		$changed(so_out) |-> $past(sck_fall))
		else $error("Output changed away from a falling clock edge");

	wel_set_a: assert property (@(posedge clk) disable iff (!nrst)
		sck_rise && st_reg.armed && !cs_n_s && !cs_fall && (st_reg.phase == SMCF_OPCODE) &&
		(st_reg.bitcnt == SMCF_LAST_BIT) && (sh_cat == SMCF_OP_LATCH_SET)
		|=> st_reg.write_enable_flag && status_byte[1])
		else $error("Latch set command did not raise the flag");

	wel_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		cs_rise && ((st_reg.kind == SMCF_K_CLR) || (st_reg.kind == SMCF_K_WR) ||
		(st_reg.kind == SMCF_K_SWR)) |=> !st_reg.write_enable_flag [*2])
		else $error("Latch not cleared at deselect after write");

	wel_only_set_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(st_reg.write_enable_flag) |-> $past(sck_rise) && ($past(sh_cat) == SMCF_OP_LATCH_SET))
		else $error("Flag rose without latch set command");

	wr_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		mem_req.wr |-> $past(st_reg.write_enable_flag))
		else $error("Memory write issued with latch clear");

	one_opcode_a: assert property (@(posedge clk) disable iff (!nrst)
		(st_reg.phase != SMCF_OPCODE) && !cs_fall |=> st_reg.phase != SMCF_OPCODE)
		else $error("Second opcode phase within one selection");

	status_fixed_a: assert property (@(posedge clk) disable iff (!nrst)
		status_byte[6] && !status_byte[0] && (status_byte[5:4] == 2'b00))
		else $error("Fixed status bits wrong");

	addr_two_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(mem_req.rd) && (st_reg.kind == SMCF_K_RD) && $past(st_reg.phase == SMCF_ADDR)
		|-> $past(st_reg.addr_hi_done))
		else $error("Read issued before both address bytes");

	// Ignored opcodes and finished commands never reach the memory
	skip_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		(st_reg.phase == SMCF_SKIP) |-> !mem_req.rd && !mem_req.wr && !mem_req.id)
		else $error("Memory request after an ignored opcode");

	// The output is only driven while a reading command runs
	oe_read_only_a: assert property (@(posedge clk) disable iff (!nrst)
		so_oe |-> is_read_kind)
		else $error("Output driven outside a read command");

	// Sleep strobe only follows a completed sleep opcode
	sleep_src_a: assert property (@(posedge clk) disable iff (!nrst)
		sleep_req |-> $past(st_reg.phase == SMCF_OPCODE) && ($past(sh_cat) == SMCF_OP_SLEEP))
		else $error("Sleep request without sleep opcode");

	// Stores happen only inside the data phase of a memory write
	wr_kind_a: assert property (@(posedge clk) disable iff (!nrst)
		mem_req.wr |-> (st_reg.kind == SMCF_K_WR) && (st_reg.phase == SMCF_DATA))
		else $error("Store outside a memory write data phase");
endmodule

// File: verif/smcf_master.sv
// SPI master model that frames commands toward the front end
`timescale 1ns/100ps
module smcf_master (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	// ============================================================
	// Idle levels at time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end

	// Wait a number of system clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ============================================================
	// One frame; sel low keeps chip select high to show ignored traffic
	task automatic frame(input logic m3, input logic sel, input logic [7:0] tx[$],
		output logic [7:0] rx[$]);
		logic [7:0] r;
		r = 8'h00;
		rx = {};
		sck <= m3;
		tick(8);
		// New select for every opcode
		cs_n <= ~sel;
		tick(8);
		if (m3) begin
			// First toggle of an idle-high clock
			sck <= 1'b0;
			tick(8);
		end
		foreach (tx[k]) begin
			for (int i = 7; i >= 0; i--) begin
				si <= tx[k][i];
				tick(8);
				sck <= 1'b1;
				r = {r[6:0], so};
				tick(8);
				// Mode 3 leaves the clock high after the last bit
				if (!(m3 && k == tx.size() - 1 && i == 0)) begin
					sck <= 1'b0;
				end
			end
			rx.push_back(r);
		end
		tick(8);
		cs_n <= 1'b1;
		// Released data line does not keep its last level
		si <= ~si;
		tick(8);
	endtask
endmodule

// File: verif/tb_smcf_frontend.sv
// Self-checking bench of the serial memory command front end
`timescale 1ns/100ps
module tb_smcf_frontend;
	import smcf_pkg::*;

	// ============================================================
	// Signals and bookkeeping
	logic clk, nrst, cs_n, sck, si, so_out, so_oe, sleep_req, so_wire;
	smcf_mem_req_s mem_req; // Requests toward memory
	logic [7:0] rd_data, status_byte;
	logic [7:0] rx[$]; // Bytes seen on the output line
	logic [23:0] wr_log[$]; // Address and data of each store
	int n_errors, cmp_count, cycles, n_id, n_sleep, n_oe;

	assign so_wire = so_oe ? so_out : 1'bz;

	smcf_frontend dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
		.so_out(so_out), .so_oe(so_oe), .mem_req(mem_req), .rd_data(rd_data),
		.sleep_req(sleep_req), .status_byte(status_byte));

	smcf_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_wire));

	// ============================================================
	// Clock and memory stand-in: byte is low address plus 0x11
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		rd_data <= mem_req.addr[7:0] + 8'h11;
	end

	// Monitor of pulses, output enable and the run limit
	always @(posedge clk) begin
		cycles++;
		if (mem_req.wr) begin
			wr_log.push_back({mem_req.addr, mem_req.wdata});
		end
		n_id += int'(mem_req.id);
		n_sleep += int'(sleep_req);
		n_oe += int'(so_oe);
		// About 7000 cycles are needed; the ceiling leaves ample margin
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end

	// ============================================================
	// Shared helpers
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic send(input logic m3, input logic [7:0] tx[$]);
		m.frame(m3, 1'b1, tx, rx);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_reset();
		check("status after reset", status_byte, SMCF_SR_FIXED);
		check("output enable idle", so_oe, 1'b0);
	endtask

	task automatic t_latch();
		int oe0;
		oe0 = n_oe;
		send(1'b0, '{SMCF_OP_STAT_RD, 8'h00});
		check("status read mode 0", rx[1], SMCF_SR_FIXED);
		check("output driven", n_oe > oe0, 1'b1);
		// Clear after set in one frame must be ignored
		send(1'b1, '{SMCF_OP_LATCH_SET, SMCF_OP_LATCH_CLR});
		check("flag set", status_byte, 8'h42);
		send(1'b1, '{SMCF_OP_STAT_RD, 8'h00});
		check("status read mode 3", rx[1], 8'h42);
		send(1'b0, '{SMCF_OP_LATCH_CLR});
		check("flag cleared", status_byte, SMCF_SR_FIXED);
	endtask

	task automatic t_status_write();
		send(1'b0, '{SMCF_OP_STAT_WR, 8'hFF});
		check("status write refused", status_byte, SMCF_SR_FIXED);
		send(1'b0, '{SMCF_OP_LATCH_SET});
		send(1'b0, '{SMCF_OP_STAT_WR, 8'hFF});
		check("status written", status_byte, 8'hCC);
		send(1'b0, '{SMCF_OP_LATCH_SET});
		send(1'b0, '{SMCF_OP_STAT_WR, 8'h00});
		check("status restored", status_byte, SMCF_SR_FIXED);
	endtask

	task automatic t_mem_write();
		int w0;
		w0 = wr_log.size();
		send(1'b0, '{SMCF_OP_MEM_WR, 8'h12, 8'h34, 8'hA5, 8'h5A});
		check("store refused", wr_log.size() - w0, 0);
		send(1'b0, '{SMCF_OP_LATCH_SET});
		send(1'b0, '{SMCF_OP_MEM_WR, 8'h12, 8'h34, 8'hA5, 8'h5A});
		check("store count", wr_log.size() - w0, 2);
		check("first store", wr_log[w0], 24'h1234_A5);
		check("second store", wr_log[w0 + 1], 24'h1235_5A);
		check("flag after store", status_byte, SMCF_SR_FIXED);
	endtask

	task automatic t_mem_read();
		send(1'b0, '{SMCF_OP_MEM_RD, 8'hFF, 8'hFF, 8'h00, 8'h00});
		check("read at top", rx[3], 8'h10);
		check("read after wrap", rx[4], 8'h11);
		send(1'b1, '{SMCF_OP_FAST_RD, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00});
		check("fast read first", rx[4], 8'h21);
		check("fast read next", rx[5], 8'h22);
	endtask

	task automatic t_ignored();
		int oe0;
		int sl0;
		int id0;
		oe0 = n_oe;
		send(1'b0, '{8'hAA, SMCF_OP_STAT_RD, 8'h00});
		check("unknown opcode silent", n_oe - oe0, 0);
		m.frame(1'b0, 1'b0, '{SMCF_OP_LATCH_SET}, rx);
		check("deselected ignored", status_byte, SMCF_SR_FIXED);
		check("deselected silent", n_oe - oe0, 0);
		send(1'b0, '{SMCF_OP_STAT_RD, SMCF_OP_LATCH_SET, SMCF_OP_LATCH_SET});
		check("one opcode per select", status_byte, SMCF_SR_FIXED);
		sl0 = n_sleep;
		send(1'b0, '{SMCF_OP_SLEEP});
		check("sleep pulse", n_sleep - sl0, 1);
		id0 = n_id;
		send(1'b0, '{SMCF_OP_IDENT, 8'h00});
		check("ident fetch", n_id > id0, 1'b1);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		// Settling time before the first select
		repeat (8) @(posedge clk);
		t_reset();
		t_latch();
		t_status_write();
		t_mem_write();
		t_mem_read();
		t_ignored();
		summarize();
	end
endmodule
